// ===== hdl/pkse_core.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - entry style setting: enter or timed
// - bank setup always uses enter style
// - edit flashes first digit or whole text
// - enter starts edit, enter again commits
// - timed style: left/down/up starts edit
// - timed style commits after 2 s idle
// - up/down change value, left moves digit
// - locked items never start edit
// - parameter key discards edit, next item
// - display/mode discard, back to operation
// - display on operation discards, next item
// - manual output edit keeps flashing, drives output
// - parameter+left steps back, 2 s ignored
// - display+left steps operation items back
// - mode held 1 s performs selected action
// - run label flashes, hold switches to run
// - disabled or invalid action does nothing
// - mode off operation returns, needs re-press
// - tier only hides items
// - run and ready states kept
// - auto/manual, local/remote, autotune states
module pkse_core import pkse_pkg::*; #(
	parameter int IDLE_CYCLES = IDLE_CYC,
	parameter int COMBO_CYCLES = COMBO_CYC,
	parameter int MODE_CYCLES = MODE_CYC,
	parameter int DEB_CYCLES = DEB_CYC,
	parameter bit HAS_REMOTE = 1'b1
) (
	// system
	input wire logic clock,
	input wire logic reset_n,
	// front panel and plant
	input wire pkse_keys_t keys_raw,
	input wire logic [15:0] process_value,
	input wire logic digital_input,
	input wire logic autotune_done,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// display and modes
	output pkse_disp_t disp,
	output pkse_mode_t mode_state,
	output logic [15:0] manipulated_output
);
	pkse_keys_t k, kp, press, rel;
	pkse_state_t state, next_state;
	pkse_page_t page, next_page;
	logic [2:0] item, next_item, item_max;
	logic [15:0] edit_val, next_val, cur_val;
	logic [1:0] digit, next_digit;
	logic run_flash, next_flash, commit, fire, used, next_used;
	logic change, idle_done, combo_done, mode_done;
	logic timed, ed_ok, act_ok, mv_edit, bus_wr, at_go;
	logic [5:0] ctrl;
	logic [15:0] settings [NITEM];
	pkse_act_t act;

	function automatic logic [15:0] step_of(input logic [1:0] d);
		case (d)
			2'h0: step_of = 16'h0001;
			2'h1: step_of = 16'h000a;
			2'h2: step_of = 16'h0064;
			default: step_of = 16'h03e8;
		endcase
	endfunction

	function automatic logic is_text(input logic [2:0] it);
		is_text = (it == IT_RUN) || (it == IT_AM);
	endfunction

	// keys are filtered before any timing
	pkse_debounce #(.N(NKEY), .CYC(DEB_CYCLES)) u_deb (
		.clock(clock),
		.reset_n(reset_n),
		.raw(keys_raw),
		.clean(k)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) kp <= '0;
		else kp <= k;
	end
	assign press = k & ~kp;
	assign rel = kp & ~k;
	assign change = (k != kp);

	// every key change restarts all three timers
	pkse_timer #(.CYC(IDLE_CYCLES)) u_idle (
		.clock(clock),
		.reset_n(reset_n),
		.run(state == ST_EDIT),
		.clear(change),
		.done(idle_done)
	);
	pkse_timer #(.CYC(COMBO_CYCLES)) u_combo (
		.clock(clock),
		.reset_n(reset_n),
		.run(k.para && k.left),
		.clear(change),
		.done(combo_done)
	);
	pkse_timer #(.CYC(MODE_CYCLES)) u_mode (
		.clock(clock),
		.reset_n(reset_n),
		.run(k.mode),
		.clear(change),
		.done(mode_done)
	);

	// decode of settings and current item
	assign act = pkse_act_t'(ctrl[C_ACT+:2]);
	assign timed = ctrl[C_STYLE] && (page == PG_OPER || page == PG_USER);
	assign mv_edit = state == ST_EDIT && page == PG_OPER && item == IT_MV;
	// tier hides items only; hidden settings stay in force
	assign item_max = (ctrl[C_TIER+:2] == 2'h0) ? 3'h3 :
		(ctrl[C_TIER+:2] == 2'h1) ? 3'h5 : 3'h7;
	assign ed_ok = !(page == PG_OPER && item == IT_PVSP) &&
		!(item == IT_RUN && ctrl[C_DILOCK]) &&
		!(page == PG_OPER && item == IT_MV && !mode_state.manual);
	assign act_ok = (act == ACT_RUN && !ctrl[C_DILOCK]) ||
		(act == ACT_AM && !mode_state.autotune) ||
		(act == ACT_RSP && HAS_REMOTE);
	always_comb begin
		case (item)
			IT_RUN: cur_val = {15'h0, mode_state.run};
			IT_AM: cur_val = {15'h0, mode_state.manual};
			default: cur_val = settings[item];
		endcase
	end

	// key interpreter
	always_comb begin
		next_state = state;
		next_page = page;
		next_item = item;
		next_val = edit_val;
		next_digit = digit;
		next_flash = run_flash;
		next_used = used;
		commit = 1'b0;
		fire = 1'b0;
		if (!k.para && !k.disp) next_used = 1'b0;
		case (state)
			ST_BROWSE: begin
				if (press.mode) begin
					if (page != PG_OPER) begin
						next_page = PG_OPER;
						next_item = IT_PVSP;
						next_state = ST_LOCK;
					end else begin
						next_state = ST_HOLD;
						next_flash = act == ACT_RUN && act_ok &&
							!mode_state.run && item == IT_PVSP;
					end
				end else if (press.left && k.disp && page == PG_OPER) begin
					next_used = 1'b1;
					next_item = (item == 3'h0) ? item_max : 3'(item - 3'h1);
				end else if (press.left && k.para) begin
					next_used = 1'b1;
				end else if (rel.left && k.para && !combo_done &&
					page != PG_OPER) begin
					next_item = (item == 3'h0) ? item_max : 3'(item - 3'h1);
				end else if (rel.para && !used) begin
					if (page == PG_OPER) begin
						next_page = PG_PARAM;
						next_item = 3'h0;
					end else if (item >= item_max) begin
						next_page = (page == PG_USER) ? PG_PARAM :
							pkse_page_t'(2'(page + 2'h1));
						next_item = 3'h0;
					end else begin
						next_item = 3'(item + 3'h1);
					end
				end else if (rel.disp && !used) begin
					if (page != PG_OPER) begin
						next_page = PG_OPER;
						next_item = 3'h0;
					end else begin
						next_item = (item >= item_max) ? 3'h0 : 3'(item + 3'h1);
					end
				end else if (ed_ok && ((!timed && press.enter) ||
					(timed && !k.para && !k.disp &&
					(press.left || press.down || press.up)))) begin
					next_state = ST_EDIT;
					next_val = cur_val;
					next_digit = 2'h0;
				end
			end
			ST_EDIT: begin
				if (press.mode) begin
					next_page = PG_OPER;
					next_item = IT_PVSP;
					next_state = ST_LOCK;
				end else if (press.disp) begin
					next_used = 1'b1;
					next_state = ST_BROWSE;
					if (page == PG_OPER) begin
						next_item = (item >= item_max) ? 3'h0 : 3'(item + 3'h1);
					end else begin
						next_page = PG_OPER;
						next_item = 3'h0;
					end
				end else if (press.para) begin
					next_used = 1'b1;
					next_state = ST_BROWSE;
					next_item = (item >= item_max) ? 3'h0 : 3'(item + 3'h1);
				end else if (press.enter && !timed) begin
					commit = 1'b1;
					next_state = ST_BROWSE;
				end else if (timed && idle_done) begin
					commit = 1'b1;
					// manual output edit stays live after the commit
					if (!mv_edit) next_state = ST_BROWSE;
				end else if (is_text(item) && (press.up || press.down)) begin
					next_val = {15'h0, ~edit_val[0]};
				end else if (press.up) begin
					next_val = edit_val + step_of(digit);
				end else if (press.down) begin
					next_val = edit_val - step_of(digit);
				end else if (press.left && !is_text(item)) begin
					next_digit = 2'(digit + 2'h1);
				end
			end
			ST_HOLD: begin
				if (!k.mode) begin
					next_state = ST_BROWSE;
					next_flash = 1'b0;
				end else if (mode_done) begin
					fire = act_ok;
					next_flash = 1'b0;
					next_state = ST_LOCK;
				end
			end
			ST_LOCK: begin
				if (!k.mode) next_state = ST_BROWSE;
			end
			default: next_state = ST_BROWSE;
		endcase
	end

	// interpreter state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_BROWSE;
			page <= PG_OPER;
			item <= 3'h0;
			edit_val <= 16'h0;
			digit <= 2'h0;
			run_flash <= 1'b0;
			used <= 1'b0;
		end else begin
			state <= next_state;
			page <= next_page;
			item <= next_item;
			edit_val <= next_val;
			digit <= next_digit;
			run_flash <= next_flash;
			used <= next_used;
		end
	end

	// operating modes; a digital input assignment overrides the panel
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_state <= '0;
		end else begin
			if (ctrl[C_DILOCK]) mode_state.run <= digital_input;
			else if (fire && act == ACT_RUN) mode_state.run <= 1'b1;
			else if (commit && item == IT_RUN) mode_state.run <= edit_val[0];
			if (fire && act == ACT_AM) mode_state.manual <= ~mode_state.manual;
			else if (commit && item == IT_AM)
				mode_state.manual <= edit_val[0];
			if (fire && act == ACT_RSP) mode_state.remote <= ~mode_state.remote;
			// tuning only runs in run and auto
			if (!mode_state.run || mode_state.manual || autotune_done)
				mode_state.autotune <= 1'b0;
			else if (at_go) mode_state.autotune <= 1'b1;
		end
	end

	// avalon: one wait state, answer in the second cycle of a request
	assign bus_wr = write && !waitrequest;
	assign at_go = bus_wr && address == OFS_CTRL && byteenable[0] &&
		writedata[C_ATGO];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			waitrequest <= 1'b1;
			readdata <= 32'h0;
		end else begin
			waitrequest <= !((read || write) && waitrequest);
			if ((read || write) && waitrequest) begin
				if (address == OFS_CTRL) readdata <= {26'h0, ctrl};
				else if (address == OFS_STAT)
					readdata <= {22'h0, mode_state, state == ST_EDIT, item, page};
				else if (address == OFS_MV) readdata <= {16'h0, manipulated_output};
				else if (address[5] && address[1:0] == 2'h0)
					readdata <= {16'h0, settings[address[4:2]]};
				else readdata <= 32'h0;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) ctrl <= CTRL_RST;
		else if (bus_wr && address == OFS_CTRL && byteenable[0])
			ctrl <= writedata[5:0];
	end

	// setting store; a panel commit wins over a bus write
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NITEM; i++) settings[i] <= 16'h0;
		end else if (commit) begin
			settings[item] <= edit_val;
		end else if (bus_wr && address[5] && address[1:0] == 2'h0) begin
			if (byteenable[0]) settings[address[4:2]][7:0] <= writedata[7:0];
			if (byteenable[1]) settings[address[4:2]][15:8] <= writedata[15:8];
		end
	end

	// display and output drive
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			disp <= '0;
			manipulated_output <= 16'h0;
		end else begin
			disp.page <= page;
			disp.item <= item;
			disp.value <= (state == ST_EDIT) ? edit_val :
				(page == PG_OPER && item == IT_PVSP) ? process_value : cur_val;
			disp.editing <= state == ST_EDIT;
			disp.flash_all <= state == ST_EDIT && is_text(item);
			disp.digit <= digit;
			disp.run_flash <= run_flash;
			manipulated_output <= mv_edit ? edit_val : settings[IT_MV];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_mode_run_fire: assert property (
		state == ST_HOLD && k.mode && mode_done && act == ACT_RUN && act_ok
		|=> mode_state.run ##1 disp.run_flash == 1'b0)
		else $error("mode hold did not switch to run");
	a_hold_off_none: assert property (
		state == ST_HOLD && act == ACT_OFF |-> !fire)
		else $error("disabled mode action fired");
	a_lock_no_fire: assert property (
		state == ST_BROWSE && press.mode && page != PG_OPER
		|=> state == ST_LOCK && page == PG_OPER)
		else $error("mode key off operation did not return and lock");
	a_enter_start: assert property (
		state == ST_BROWSE && press.enter && !timed && ed_ok &&
		!press.mode && !k.para && !k.disp && !rel.para && !rel.disp &&
		!rel.left |=> state == ST_EDIT ##1 disp.editing && disp.digit == 2'h0)
		else $error("enter did not begin edit");
	a_locked_item: assert property (
		state == ST_BROWSE && item == IT_RUN && ctrl[C_DILOCK]
		|=> state != ST_EDIT)
		else $error("locked item entered edit");
	a_bank_enter_only: assert property (
		state == ST_BROWSE && page == PG_BANK && !press.enter
		|=> state != ST_EDIT)
		else $error("bank display started edit without enter");
	a_idle_commit: assert property (
		state == ST_EDIT && timed && idle_done && !change && !mv_edit
		|=> state == ST_BROWSE && settings[$past(item)] == $past(edit_val))
		else $error("timed commit missing");
	a_mv_follows: assert property (
		mv_edit |=> manipulated_output == $past(edit_val))
		else $error("output does not follow edited value");
	a_oper_discard: assert property (
		state == ST_EDIT && page == PG_OPER && press.disp && !press.mode
		|=> state == ST_BROWSE && page == PG_OPER && $stable(settings[IT_MV]))
		else $error("display key did not discard edit");
	a_dilock_run: assert property (
		ctrl[C_DILOCK] |=> mode_state.run == $past(digital_input))
		else $error("run not following digital input");
	a_bus_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not in one wait state");

	c_enter_commit: cover property (state == ST_EDIT && press.enter && !timed);
	c_mode_fire: cover property (fire && act == ACT_RUN);
	c_combo_back: cover property (rel.left && k.para && !combo_done);
	c_timed_commit: cover property (commit && timed);
endmodule
`default_nettype wire

// ===== hdl/pkse_pkg.sv
package pkse_pkg;
	// timing
	localparam int CLK_HZ = 20_000_000;
	localparam int IDLE_MS = 2000;
	localparam int COMBO_MS = 2000;
	localparam int MODE_MS = 1000;
	localparam int DEB_MS = 5;
	localparam int IDLE_CYC = CLK_HZ / 1000 * IDLE_MS;
	localparam int COMBO_CYC = CLK_HZ / 1000 * COMBO_MS;
	localparam int MODE_CYC = CLK_HZ / 1000 * MODE_MS;
	localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
	// register map, byte addresses
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_STAT = 6'h04;
	localparam logic [5:0] OFS_MV = 6'h08;
	localparam logic [5:0] OFS_SET = 6'h20;
	// control fields
	localparam int C_STYLE = 0;
	localparam int C_ACT = 1;
	localparam int C_TIER = 3;
	localparam int C_DILOCK = 5;
	localparam int C_ATGO = 6;
	localparam logic [5:0] CTRL_RST = 6'h08;
	// items
	localparam int NITEM = 8;
	localparam logic [2:0] IT_PVSP = 3'h0;
	localparam logic [2:0] IT_MV = 3'h1;
	localparam logic [2:0] IT_RUN = 3'h2;
	localparam logic [2:0] IT_AM = 3'h3;
	localparam int NKEY = 7;
	typedef enum logic [1:0] {
		ST_BROWSE = 2'b00, ST_HOLD = 2'b01, ST_LOCK = 2'b11, ST_EDIT = 2'b10
	} pkse_state_t;
	typedef enum logic [1:0] {
		PG_OPER = 2'h0, PG_PARAM = 2'h1, PG_BANK = 2'h2, PG_USER = 2'h3
	} pkse_page_t;
	typedef enum logic [1:0] {
		ACT_OFF = 2'h0, ACT_AM = 2'h1, ACT_RUN = 2'h2, ACT_RSP = 2'h3
	} pkse_act_t;
	typedef struct packed {
		logic disp;
		logic para;
		logic mode;
		logic enter;
		logic left;
		logic down;
		logic up;
	} pkse_keys_t;
	typedef struct packed {
		pkse_page_t page;
		logic [2:0] item;
		logic [15:0] value;
		logic editing;
		logic flash_all;
		logic [1:0] digit;
		logic run_flash;
	} pkse_disp_t;
	typedef struct packed {
		logic run;
		logic manual;
		logic remote;
		logic autotune;
	} pkse_mode_t;
endpackage

// ===== hdl/pkse_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module pkse_debounce #(
	parameter int N = 7,
	parameter int CYC = 100000
) (
	// system
	input wire logic clock,
	input wire logic reset_n,
	// keys
	input wire logic [N-1:0] raw,
	output logic [N-1:0] clean
);
	// a key level is accepted only after it held steady for CYC cycles
	for (genvar i = 0; i < N; i++) begin : g_key
		logic [31:0] cnt;
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				cnt <= 32'h0;
				clean[i] <= 1'b0;
			end else if (raw[i] == clean[i]) begin
				cnt <= 32'h0;
			end else if (cnt == 32'(CYC - 1)) begin
				cnt <= 32'h0;
				clean[i] <= raw[i];
			end else begin
				cnt <= cnt + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== hdl/pkse_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pkse_timer #(
	parameter int CYC = 4
) (
	// system
	input wire logic clock,
	input wire logic reset_n,
	// control
	input wire logic run,
	input wire logic clear,
	output logic done
);
	logic [31:0] cnt;
	// done rises CYC cycles after run with no clear; stays until dropped
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 32'h0;
			done <= 1'b0;
		end else if (clear || !run) begin
			cnt <= 32'h0;
			done <= 1'b0;
		end else if (cnt != 32'(CYC - 1)) begin
			cnt <= cnt + 32'h1;
		end else begin
			done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/pkse_operator.sv
`timescale 1ns/10ps
`default_nettype none
// operator at the front panel: keys change just after an edge and then stand
module pkse_operator import pkse_pkg::*; (
	// system
	input wire logic clock,
	// panel
	output pkse_keys_t keys
);
	initial keys = '0;

	// press (on=1) or release keys, then hold the new level for some cycles
	task automatic set_keys(input logic [NKEY-1:0] m, input logic on,
			input int hold);
		@(posedge clock);
		keys <= pkse_keys_t'(on ? (keys | m) : (keys & ~m));
		repeat (hold) @(posedge clock);
	endtask

	// a short press, long enough to pass the debounce filter
	task automatic tap(input logic [NKEY-1:0] m);
		set_keys(m, 1'b1, 8);
		set_keys(m, 1'b0, 8);
	endtask
endmodule
`default_nettype wire

// ===== testbench/test_panel_key_setting_editor.sv
`timescale 1ns/10ps
`default_nettype none
module test_panel_key_setting_editor;
	import pkse_pkg::*;
	localparam int IDLE_P = 50;
	localparam int MODE_P = 30;
	localparam logic [6:0] K_DISP = 7'h40;
	localparam logic [6:0] K_PARA = 7'h20;
	localparam logic [6:0] K_MODE = 7'h10;
	localparam logic [6:0] K_ENT = 7'h08;
	localparam logic [6:0] K_LEFT = 7'h04;
	localparam logic [6:0] K_DOWN = 7'h02;
	localparam logic [6:0] K_UP = 7'h01;
	typedef struct {
		logic [5:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pkse_row_t;
	logic clock, reset_n, read, write, waitrequest, digital_input;
	logic autotune_done;
	logic [5:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable;
	logic [15:0] process_value, manipulated_output;
	pkse_keys_t keys_raw;
	pkse_disp_t disp;
	pkse_mode_t mode_state;
	int errors = 0;
	int tests_run = 0;
	pkse_row_t rows [6];

	pkse_operator pkse_operator_i (
		.clock(clock),
		.keys(keys_raw)
	);
	pkse_core #(.IDLE_CYCLES(IDLE_P), .COMBO_CYCLES(40),
		.MODE_CYCLES(MODE_P), .DEB_CYCLES(2)) pkse_core_i (
		.clock(clock), .reset_n(reset_n), .keys_raw(keys_raw),
		.process_value(process_value), .digital_input(digital_input),
		.autotune_done(autotune_done), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .disp(disp),
		.mode_state(mode_state), .manipulated_output(manipulated_output)
	);

	// 20 MHz clock
	always #25 clock = ~clock;

	task automatic complete_run;
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check_val(input string n, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic check_bit(input string n, input logic e, input logic g);
		check_val(n, {31'h0, e}, {31'h0, g});
	endtask

	// one avalon transfer; request stands until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a,
			input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 100);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 100)
			check_bit("waitrequest answer", 1'b0, waitrequest);
	endtask

	task automatic wr_ctrl(input logic [31:0] d);
		bus(1'b1, OFS_CTRL, d, q);
	endtask

	// display held, left tapped, display released: one step back
	task automatic step_back;
		pkse_operator_i.set_keys(K_DISP, 1'b1, 8);
		pkse_operator_i.tap(K_LEFT);
		pkse_operator_i.set_keys(K_DISP, 1'b0, 8);
	endtask

	// watchdog: the whole sequence needs well under 20000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		complete_run();
	end

	initial begin
		rows[0] = '{6'h20, 32'h0000_1234, 32'h0000_1234};
		rows[1] = '{6'h3c, 32'hffff_5678, 32'h0000_5678};
		rows[2] = '{6'h30, 32'h0000_0100, 32'h0000_0100};
		rows[3] = '{6'h10, 32'h0000_00aa, 32'h0000_0000};
		rows[4] = '{6'h08, 32'h0000_5555, 32'h0000_0000};
		rows[5] = '{6'h00, 32'h0000_0018, 32'h0000_0018};
		clock = 1'b0;
		reset_n = 1'b0;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'hf;
		process_value = 16'h0123;
		digital_input = 1'b0;
		autotune_done = 1'b0;
		repeat (5) @(posedge clock);
		check_bit("waitrequest in reset", 1'b1, waitrequest);
		check_val("disp in reset", 32'h0, 32'(disp));
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0, q);
		check_val("ctrl reset", {26'h0, CTRL_RST}, q);
		repeat (8) @(posedge clock);
		check_val("item0 value", 32'h0123, {16'h0, disp.value});
		// register rows: write, then read back
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d, q);
			bus(1'b0, rows[i].a, 32'h0, q);
			check_val("register row", rows[i].e, q);
		end
		// hold with the action disabled does nothing
		pkse_operator_i.set_keys(K_MODE, 1'b1, MODE_P + 10);
		check_bit("run disabled hold", 1'b0, mode_state.run);
		pkse_operator_i.set_keys(K_MODE, 1'b0, 8);
		// run selection by a held mode key
		wr_ctrl(32'h1c);
		pkse_operator_i.set_keys(K_MODE, 1'b1, 8);
		check_bit("run label flash", 1'b1, disp.run_flash);
		repeat (MODE_P + 8) @(posedge clock);
		check_bit("run after hold", 1'b1, mode_state.run);
		check_bit("flash stops", 1'b0, disp.run_flash);
		pkse_operator_i.set_keys(K_MODE, 1'b0, 8);
		check_val("display restored", 32'h0, {29'h0, disp.item});
		// auto/manual by hold, then manual output edit
		wr_ctrl(32'h1a);
		pkse_operator_i.set_keys(K_MODE, 1'b1, MODE_P + 10);
		pkse_operator_i.set_keys(K_MODE, 1'b0, 8);
		check_bit("manual mode", 1'b1, mode_state.manual);
		pkse_operator_i.tap(K_DISP);
		pkse_operator_i.tap(K_ENT);
		pkse_operator_i.tap(K_UP);
		check_bit("mv still flashing", 1'b1, disp.editing);
		check_val("mv driven", 32'h1, {16'h0, manipulated_output});
		pkse_operator_i.tap(K_ENT);
		// run item is text: whole string flashes, commit stops control
		pkse_operator_i.tap(K_DISP);
		pkse_operator_i.tap(K_ENT);
		check_bit("text flash", 1'b1, disp.flash_all);
		pkse_operator_i.tap(K_DOWN);
		pkse_operator_i.tap(K_ENT);
		check_bit("ready committed", 1'b0, mode_state.run);
		check_bit("edit ended", 1'b0, disp.editing);
		// numeric edit on item 4: digit steps 1 then 10
		pkse_operator_i.tap(K_DISP);
		pkse_operator_i.tap(K_DISP);
		pkse_operator_i.tap(K_ENT);
		check_bit("numeric edit", 1'b1, disp.editing);
		check_bit("numeric no text", 1'b0, disp.flash_all);
		check_val("first digit", 32'h0, {30'h0, disp.digit});
		pkse_operator_i.tap(K_UP);
		pkse_operator_i.tap(K_LEFT);
		check_val("digit moved", 32'h1, {30'h0, disp.digit});
		pkse_operator_i.tap(K_UP);
		check_val("value edited", 32'h010b, {16'h0, disp.value});
		pkse_operator_i.tap(K_ENT);
		bus(1'b0, 6'h30, 32'h0, q);
		check_val("setting committed", 32'h010b, q);
		// display during an operation edit discards and advances
		pkse_operator_i.tap(K_ENT);
		pkse_operator_i.tap(K_UP);
		pkse_operator_i.tap(K_DISP);
		check_bit("edit dropped", 1'b0, disp.editing);
		check_val("next item", 32'h5, {29'h0, disp.item});
		bus(1'b0, 6'h30, 32'h0, q);
		check_val("setting kept", 32'h010b, q);
		// timed style: up starts the edit, idle commits it
		wr_ctrl(32'h19);
		step_back();
		check_val("stepped back", 32'h4, {29'h0, disp.item});
		pkse_operator_i.tap(K_UP);
		check_bit("timed start", 1'b1, disp.editing);
		pkse_operator_i.tap(K_UP);
		repeat (IDLE_P - 25) @(posedge clock);
		check_bit("before idle", 1'b1, disp.editing);
		repeat (40) @(posedge clock);
		check_bit("idle commit", 1'b0, disp.editing);
		bus(1'b0, 6'h30, 32'h0, q);
		check_val("timed value", 32'h010c, q);
		// run locked to the digital input
		digital_input <= 1'b1;
		wr_ctrl(32'h38);
		step_back();
		step_back();
		check_bit("run from input", 1'b1, mode_state.run);
		pkse_operator_i.tap(K_ENT);
		check_bit("locked item", 1'b0, disp.editing);
		// mode on the parameter page returns, hold does not select
		wr_ctrl(32'h1a);
		pkse_operator_i.tap(K_PARA);
		check_val("param page", 32'(PG_PARAM), 32'(disp.page));
		pkse_operator_i.set_keys(K_MODE, 1'b1, MODE_P + 10);
		check_val("back to operation", 32'(PG_OPER), 32'(disp.page));
		check_bit("no selection", 1'b1, mode_state.manual);
		pkse_operator_i.set_keys(K_MODE, 1'b0, 8);
		// bank page: para forward, para+left back, long combo ignored
		for (int j = 0; j < 9; j++)
			pkse_operator_i.tap(K_PARA);
		check_val("bank page", 32'(PG_BANK), 32'(disp.page));
		pkse_operator_i.set_keys(K_PARA, 1'b1, 8);
		pkse_operator_i.tap(K_LEFT);
		pkse_operator_i.set_keys(K_PARA, 1'b0, 8);
		check_val("para left back", 32'h7, {29'h0, disp.item});
		pkse_operator_i.set_keys(K_PARA, 1'b1, 8);
		pkse_operator_i.set_keys(K_LEFT, 1'b1, 50);
		pkse_operator_i.set_keys(K_LEFT, 1'b0, 8);
		pkse_operator_i.set_keys(K_PARA, 1'b0, 8);
		check_val("long combo ignored", 32'h7, {29'h0, disp.item});
		// a bank edit is dropped by para or display, enter style only
		pkse_operator_i.tap(K_ENT);
		pkse_operator_i.tap(K_UP);
		pkse_operator_i.tap(K_PARA);
		check_bit("bank edit dropped", 1'b0, disp.editing);
		check_val("bank next item", 32'h0, {29'h0, disp.item});
		bus(1'b0, 6'h3c, 32'h0, q);
		check_val("bank value kept", 32'h5678, q);
		wr_ctrl(32'h1b);
		pkse_operator_i.tap(K_UP);
		check_bit("bank ignores timed", 1'b0, disp.editing);
		pkse_operator_i.tap(K_ENT);
		check_bit("bank enter edit", 1'b1, disp.editing);
		pkse_operator_i.tap(K_DISP);
		check_val("bank to operation", 32'(PG_OPER), 32'(disp.page));
		check_bit("bank display drop", 1'b0, disp.editing);
		// second reset in mid-run
		reset_n <= 1'b0;
		repeat (3) @(posedge clock);
		check_val("modes in reset", 32'h0, 32'(mode_state));
		reset_n <= 1'b1;
		bus(1'b0, OFS_CTRL, 32'h0, q);
		check_val("ctrl after reset", {26'h0, CTRL_RST}, q);
		complete_run();
	end
endmodule
`default_nettype wire
